// >>> shared/gflm_pkg.sv
// constants and types for the gas flow limit monitor
package gflm_pkg;
  // flow rate width and parameter ranges
  localparam int FLOW_W = 8;
  localparam logic [7:0] MAX_LIM_MIN = 8'h05;
  localparam logic [7:0] MAX_LIM_MAX = 8'hFF;
  localparam logic [7:0] MIN_LIM_MIN = 8'h05;
  localparam logic [7:0] MIN_LIM_MAX = 8'h64;
  // hold-off in tenths of a second
  localparam logic [7:0] HOLD_MIN = 8'h05;
  localparam logic [7:0] HOLD_MAX = 8'h64;
  // reset values of the settings
  localparam logic [7:0] MAX_LIM_RST = 8'hC8;
  localparam logic [7:0] MIN_LIM_RST = 8'h0A;
  localparam logic [7:0] HOLD_RST = 8'h0A;
  // volume wraps above this many tenths (6550.0)
  localparam logic [15:0] VOL_MAX = 16'hFFDC;
  // time bases
  localparam int CLK_HZ = 100_000_000;
  localparam int TENTH_NS = 100_000_000;
  localparam int CLK_NS = 10;
  localparam int TENTH_CYC = TENTH_NS / CLK_NS;
  localparam int HUND_CYC = TENTH_CYC / 10;
  localparam int SEC_CYC = CLK_HZ;
  localparam int DEB_US = 10_000;
  localparam int DEB_CYC = DEB_US * 1000 / CLK_NS;
  // float charge timer 22.5 minutes in seconds
  localparam int FLOAT_S = 1350;
  localparam logic [5:0] SIXTY_M1 = 6'h3B;
  // menu items
  typedef enum logic [3:0] {
    MI_MAX_LIM, MI_MIN_LIM, MI_HOLD, MI_ALARM_EN, MI_PEAK_EN,
    MI_LOG_EN, MI_CLR_TIME, MI_CLR_VOL
  } gflm_item_t;
  localparam gflm_item_t MI_LAST = MI_CLR_VOL;
  typedef enum logic [1:0] {
    MS_NORMAL, MS_BROWSE, MS_EDIT
  } gflm_mstate_t;
endpackage : gflm_pkg

// >>> src/gflm_debounce.sv
// button synchroniser and debouncer
`timescale 1ns/1ps
`default_nettype none
module gflm_debounce #(
  parameter int CNT = 1_000_000
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // raw pin and clean level
  input wire logic pin,
  output logic level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic lvl;
    logic [31:0] cnt;
  } gflm_db_t;
  gflm_db_t r_q, r_d;
  // level changes only after the synced pin is stable for cnt cycles
  always_comb begin
    r_d = r_q;
    r_d.s1 = pin;
    r_d.s2 = r_q.s1;
    if (r_q.s2 == r_q.lvl) begin
      r_d.cnt = '0;
    end else if (r_q.cnt >= 32'(CNT - 1)) begin
      r_d.cnt = '0;
      r_d.lvl = r_q.s2;
    end else begin
      r_d.cnt = r_q.cnt + 32'h1;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end
  assign level = r_q.lvl;
endmodule : gflm_debounce
`default_nettype wire

// >>> src/gflm_monitor.sv
// gas flow limit monitor: relay, peak capture, usage log and menu
`timescale 1ns/1ps
`default_nettype none
module gflm_monitor import gflm_pkg::*; #(
  parameter int DEB_CYCLES = DEB_CYC,
  parameter int TENTH_CYCLES = TENTH_CYC,
  parameter int HUND_CYCLES = HUND_CYC,
  parameter int SEC_CYCLES = SEC_CYC,
  parameter int FLOAT_SECONDS = FLOAT_S
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // flow sensor, same clock domain
  input wire logic [FLOW_W-1:0] flow_rate,
  // front panel buttons, raw pins
  input wire logic btn_up_pin,
  input wire logic btn_down_pin,
  // charger status pins
  input wire logic charging_pin,
  input wire logic charge_current_low_pin,
  // relay contacts
  output logic relay_contact_a,
  output logic relay_contact_b,
  // charge lamp
  output logic charge_indicator,
  // menu view
  output logic [1:0] menu_state,
  output logic [3:0] menu_item,
  output logic [7:0] menu_value,
  // live settings
  output logic [7:0] max_limit,
  output logic [7:0] min_limit,
  output logic [7:0] hold_off,
  output logic alarm_en,
  output logic peak_en,
  output logic log_en,
  // readouts
  output logic flow_active,
  output logic peak_valid,
  output logic [7:0] peak_rate,
  output logic [15:0] peak_time_hund,
  output logic [15:0] total_vol_tenths,
  output logic [15:0] total_hours,
  output logic [5:0] total_minutes,
  output logic [5:0] total_seconds
);
  typedef struct packed {
    gflm_mstate_t ms;
    gflm_item_t item;
    logic [7:0] edit_val;
    logic [7:0] max_lim;
    logic [7:0] min_lim;
    logic [7:0] hold;
    logic alarm_en;
    logic peak_en;
    logic log_en;
    logic up_prev;
    logic dn_prev;
    logic chord_lock;
    logic flow_prev;
    logic [7:0] hold_cnt;
    logic [31:0] tenth_cnt;
    logic relay;
    logic [7:0] peak;
    logic [15:0] peak_t;
    logic [31:0] hund_cnt;
    logic [15:0] vol;
    logic [47:0] vol_acc;
    logic [15:0] hrs;
    logic [5:0] mins;
    logic [5:0] secs;
    logic [31:0] sec_cnt;
    logic ch_s1;
    logic ch_s2;
    logic lo_s1;
    logic lo_s2;
    logic [15:0] float_cnt;
    logic [31:0] float_sub;
    logic chg_led;
    logic peak_vis;
  } gflm_st_t;
  gflm_st_t r_q, r_d;
  logic up_lvl;
  logic dn_lvl;
  // debounced buttons
  gflm_debounce #(.CNT(DEB_CYCLES)) u_db_up (
    .core_clk(core_clk), .rst(rst), .pin(btn_up_pin), .level(up_lvl));
  gflm_debounce #(.CNT(DEB_CYCLES)) u_db_dn (
    .core_clk(core_clk), .rst(rst), .pin(btn_down_pin), .level(dn_lvl));
  logic chord;
  logic up_ev;
  logic dn_ev;
  logic flowing;
  logic in_band;
  logic [7:0] cur_val;
  // single presses act on release so a chord is never seen as two singles
  always_comb begin
    chord = up_lvl && dn_lvl && !r_q.chord_lock;
    up_ev = r_q.up_prev && !up_lvl && !dn_lvl && !r_q.chord_lock;
    dn_ev = r_q.dn_prev && !dn_lvl && !up_lvl && !r_q.chord_lock;
    flowing = flow_rate != '0;
    cur_val = 8'h00;
    case (r_q.item)
      MI_MAX_LIM: cur_val = r_q.max_lim;
      MI_MIN_LIM: cur_val = r_q.min_lim;
      MI_HOLD: cur_val = r_q.hold;
      MI_ALARM_EN: cur_val = {7'h00, r_q.alarm_en};
      MI_PEAK_EN: cur_val = {7'h00, r_q.peak_en};
      MI_LOG_EN: cur_val = {7'h00, r_q.log_en};
      default: cur_val = 8'h00;
    endcase
    // lower limit always, upper only after hold-off
    in_band = flowing && (flow_rate > r_q.min_lim)
      && ((r_q.hold_cnt != '0) || !r_q.flow_prev || (flow_rate < r_q.max_lim));
  end
  // edit value step within the item's range
  function automatic logic [7:0] step_val(input gflm_item_t it, input logic [7:0] v,
                                          input logic up);
    logic [7:0] lo;
    logic [7:0] hi;
    lo = 8'h00;
    hi = 8'h01;
    if (it == MI_MAX_LIM) begin
      lo = MAX_LIM_MIN;
      hi = MAX_LIM_MAX;
    end else if (it == MI_MIN_LIM) begin
      lo = MIN_LIM_MIN;
      hi = MIN_LIM_MAX;
    end else if (it == MI_HOLD) begin
      lo = HOLD_MIN;
      hi = HOLD_MAX;
    end
    if (up) begin
      step_val = (v < hi) ? v + 8'h01 : hi;
    end else begin
      step_val = (v > lo) ? v - 8'h01 : lo;
    end
  endfunction : step_val
  // all next-state logic
  always_comb begin
    r_d = r_q;
    r_d.up_prev = up_lvl;
    r_d.dn_prev = dn_lvl;
    if (chord) begin
      r_d.chord_lock = 1'b1;
    end else if (!up_lvl && !dn_lvl) begin
      r_d.chord_lock = 1'b0;
    end
    // menu sequencer
    case (r_q.ms)
      MS_NORMAL: begin
        if (chord) begin
          r_d.ms = MS_BROWSE;
          r_d.item = MI_MAX_LIM;
        end
      end
      MS_BROWSE: begin
        if (chord) begin
          r_d.ms = MS_EDIT;
          r_d.edit_val = cur_val;
        end else if (up_ev) begin
          r_d.item = (r_q.item == MI_LAST) ? MI_MAX_LIM : gflm_item_t'(r_q.item + 4'h1);
        end else if (dn_ev) begin
          r_d.item = (r_q.item == MI_MAX_LIM) ? MI_LAST : gflm_item_t'(r_q.item - 4'h1);
        end
      end
      MS_EDIT: begin
        if (chord) begin
          r_d.ms = MS_NORMAL;
          case (r_q.item)
            MI_MAX_LIM: r_d.max_lim = r_q.edit_val;
            MI_MIN_LIM: r_d.min_lim = r_q.edit_val;
            MI_HOLD: r_d.hold = r_q.edit_val;
            MI_ALARM_EN: r_d.alarm_en = r_q.edit_val[0];
            MI_PEAK_EN: r_d.peak_en = r_q.edit_val[0];
            MI_LOG_EN: r_d.log_en = r_q.edit_val[0];
            default: ;
          endcase
        end else if (up_ev) begin
          r_d.edit_val = step_val(r_q.item, r_q.edit_val, 1'b1);
        end else if (dn_ev) begin
          r_d.edit_val = step_val(r_q.item, r_q.edit_val, 1'b0);
        end
      end
      default: r_d.ms = MS_NORMAL;
    endcase
    // hold-off countdown in tenths, reloaded at each new flow period
    r_d.flow_prev = flowing;
    if (flowing && !r_q.flow_prev) begin
      r_d.hold_cnt = r_q.hold;
      r_d.tenth_cnt = '0;
    end else if (flowing && r_q.hold_cnt != '0) begin
      if (r_q.tenth_cnt >= 32'(TENTH_CYCLES - 1)) begin
        r_d.tenth_cnt = '0;
        r_d.hold_cnt = r_q.hold_cnt - 8'h01;
      end else begin
        r_d.tenth_cnt = r_q.tenth_cnt + 32'h1;
      end
    end
    // relay follows band, forced off while alarms disabled
    r_d.relay = r_q.alarm_en && in_band;
    r_d.peak_vis = r_d.peak_en && !r_d.flow_prev;
    // peak capture, hundredths of a second above upper limit
    if (r_q.peak_en) begin
      if (flowing && !r_q.flow_prev) begin
        r_d.peak = flow_rate;
        r_d.peak_t = '0;
        r_d.hund_cnt = '0;
      end else if (flowing) begin
        if (flow_rate > r_q.peak) begin
          r_d.peak = flow_rate;
        end
        if (flow_rate > r_q.max_lim) begin
          if (r_q.hund_cnt >= 32'(HUND_CYCLES - 1)) begin
            r_d.hund_cnt = '0;
            r_d.peak_t = r_q.peak_t + 16'h1;
          end else begin
            r_d.hund_cnt = r_q.hund_cnt + 32'h1;
          end
        end
      end
    end
    // volume: rate is per hour, so rate*cycles summed until 36000*tenth-sec worth
    if (r_q.log_en && flowing) begin
      if (r_q.vol_acc + 48'(flow_rate) >= 48'(TENTH_CYCLES) * 48'd36000) begin
        r_d.vol_acc = r_q.vol_acc + 48'(flow_rate) - 48'(TENTH_CYCLES) * 48'd36000;
        r_d.vol = (r_q.vol >= VOL_MAX) ? 16'h0000 : r_q.vol + 16'h0001;
      end else begin
        r_d.vol_acc = r_q.vol_acc + 48'(flow_rate);
      end
      if (r_q.sec_cnt >= 32'(SEC_CYCLES - 1)) begin
        r_d.sec_cnt = '0;
        if (r_q.secs == SIXTY_M1) begin
          r_d.secs = '0;
          if (r_q.mins == SIXTY_M1) begin
            r_d.mins = '0;
            r_d.hrs = r_q.hrs + 16'h1;
          end else begin
            r_d.mins = r_q.mins + 6'h1;
          end
        end else begin
          r_d.secs = r_q.secs + 6'h1;
        end
      end else begin
        r_d.sec_cnt = r_q.sec_cnt + 32'h1;
      end
    end
    // clears act on leaving edit with yes selected
    if (r_q.ms == MS_EDIT && chord && r_q.edit_val[0]) begin
      if (r_q.item == MI_CLR_TIME) begin
        r_d.hrs = '0;
        r_d.mins = '0;
        r_d.secs = '0;
        r_d.sec_cnt = '0;
      end
      if (r_q.item == MI_CLR_VOL) begin
        r_d.vol = '0;
        r_d.vol_acc = '0;
      end
    end
    // charger lamp with float timer
    r_d.ch_s1 = charging_pin;
    r_d.ch_s2 = r_q.ch_s1;
    r_d.lo_s1 = charge_current_low_pin;
    r_d.lo_s2 = r_q.lo_s1;
    if (!r_q.ch_s2) begin
      r_d.float_cnt = '0;
      r_d.float_sub = '0;
      r_d.chg_led = 1'b0;
    end else begin
      r_d.chg_led = !r_q.lo_s2 && (r_q.float_cnt < 16'(FLOAT_SECONDS));
      if (r_q.float_cnt < 16'(FLOAT_SECONDS)) begin
        if (r_q.float_sub >= 32'(SEC_CYCLES - 1)) begin
          r_d.float_sub = '0;
          r_d.float_cnt = r_q.float_cnt + 16'h1;
        end else begin
          r_d.float_sub = r_q.float_sub + 32'h1;
        end
      end
    end
  end
  // state register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r_q <= '0;
      r_q.max_lim <= MAX_LIM_RST;
      r_q.min_lim <= MIN_LIM_RST;
      r_q.hold <= HOLD_RST;
      r_q.alarm_en <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end
  // outputs straight from state flops
  assign relay_contact_a = r_q.relay;
  assign relay_contact_b = r_q.relay;
  assign charge_indicator = r_q.chg_led;
  assign menu_state = r_q.ms;
  assign menu_item = r_q.item;
  assign menu_value = r_q.edit_val;
  assign max_limit = r_q.max_lim;
  assign min_limit = r_q.min_lim;
  assign hold_off = r_q.hold;
  assign alarm_en = r_q.alarm_en;
  assign peak_en = r_q.peak_en;
  assign log_en = r_q.log_en;
  assign flow_active = r_q.flow_prev;
  assign peak_valid = r_q.peak_vis;
  assign peak_rate = r_q.peak;
  assign peak_time_hund = r_q.peak_t;
  assign total_vol_tenths = r_q.vol;
  assign total_hours = r_q.hrs;
  assign total_minutes = r_q.mins;
  assign total_seconds = r_q.secs;
endmodule : gflm_monitor
`default_nettype wire

// >>> tb/gflm_checker.sv
// port checker for the gas flow limit monitor
`timescale 1ns/1ps
`default_nettype none
module gflm_checker import gflm_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // watched ports
  input wire logic [FLOW_W-1:0] flow_rate,
  input wire logic relay_contact_a,
  input wire logic relay_contact_b,
  input wire logic [7:0] min_limit,
  input wire logic alarm_en,
  input wire logic peak_en,
  input wire logic log_en,
  input wire logic flow_active,
  input wire logic peak_valid,
  input wire logic [7:0] peak_rate,
  input wire logic [15:0] total_vol_tenths,
  input wire logic [5:0] total_seconds,
  input wire logic [1:0] menu_state
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // both contacts are one relay, so they never disagree
  a_relay_pair: assert property (relay_contact_a == relay_contact_b)
    else $error("relay contacts differ");
  a_relay_low: assert property (relay_contact_a |-> $past(flow_rate) > $past(min_limit))
    else $error("relay on at or below lower limit");
  a_alarm_off: assert property (!$past(alarm_en) |-> !relay_contact_a)
    else $error("relay on with alarms disabled");
  a_idle_relay: assert property ($past(flow_rate) == 0 |-> !relay_contact_a)
    else $error("relay on without flow");
  a_flow_det: assert property (flow_active == ($past(flow_rate) != 0))
    else $error("flow period flag wrong");
  a_peak_view: assert property (peak_valid == (peak_en && !flow_active))
    else $error("peak readout gating wrong");
  a_peak_frozen: assert property (!$past(peak_en) |-> $stable(peak_rate))
    else $error("peak moved while disabled");
  a_peak_hold: assert property (flow_active && $past(peak_en) |-> peak_rate >= $past(flow_rate))
    else $error("peak below observed flow");
  // upper limit must be ignored on the first cycle of a period
  a_holdoff_start: assert property ($rose(flow_active) && $past(alarm_en)
    && $past(flow_rate) > $past(min_limit) |-> relay_contact_a)
    else $error("relay off at flow start");
  a_vol_wrap: assert property (total_vol_tenths <= VOL_MAX)
    else $error("volume above wrap point");
  a_log_off: assert property (!$past(log_en) && menu_state == $past(menu_state)
    |-> $stable(total_vol_tenths) && $stable(total_seconds))
    else $error("totals moved with logging off");
endmodule : gflm_checker
bind gflm_monitor gflm_checker chk_i (.*);
`default_nettype wire

// >>> tb/gflm_panel.sv
// operator model: presses and releases the front-panel buttons
`timescale 1ns/1ps
`default_nettype none
module gflm_panel (
  // clock
  input wire logic core_clk,
  // request, bit0 up and bit1 down
  input wire logic [1:0] cmd,
  input wire logic go,
  // pins and status
  output logic btn_up_pin,
  output logic btn_down_pin,
  output logic busy
);
  int cnt = 0;
  initial {btn_down_pin, btn_up_pin} = 2'h0;
  // a chord raises and drops both pins together, never as two singles
  always @(posedge core_clk) begin
    if (cnt == 0 && go) begin
      cnt <= 24;
      {btn_down_pin, btn_up_pin} <= cmd;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
    if (cnt == 13) begin
      {btn_down_pin, btn_up_pin} <= 2'h0;
    end
  end
  assign busy = go || cnt != 0;
endmodule : gflm_panel
`default_nettype wire

// >>> tb/gas_flow_limit_monitor_bench.sv
// self-checking bench for the gas flow limit monitor
`timescale 1ns/1ps
`default_nettype none
module gas_flow_limit_monitor_bench;
  import gflm_pkg::*;
  logic core_clk = 0, rst = 1, go = 0, busy, btn_up_pin, btn_down_pin;
  logic charging_pin = 0, charge_current_low_pin = 0, relay_contact_a, relay_contact_b;
  logic charge_indicator, alarm_en, peak_en, log_en, flow_active, peak_valid;
  logic [1:0] cmd = 0, menu_state;
  logic [3:0] menu_item;
  logic [7:0] flow_rate = 0, menu_value, max_limit, min_limit, hold_off, peak_rate;
  logic [15:0] peak_time_hund, total_vol_tenths, total_hours;
  logic [5:0] total_minutes, total_seconds;
  int fail_count = 0, n_checks = 0;
  // short counts keep the run brief
  gflm_monitor #(.DEB_CYCLES(4), .TENTH_CYCLES(10), .HUND_CYCLES(1), .SEC_CYCLES(20),
    .FLOAT_SECONDS(3)) dut (.*);
  gflm_panel panel (.*);
  always #5 core_clk = ~core_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // one button action, bounded wait for the operator model
  task automatic press(input logic [1:0] c);
    @(posedge core_clk);
    #1 cmd = c;
    go = 1;
    @(posedge core_clk);
    #1 go = 0;
    for (int i = 0; i < 40 && busy; i++) @(posedge core_clk);
    if (busy) begin
      fail_count++;
      conclude();
    end
  endtask : press
  // open item n, step its value once, commit
  task automatic edit(input int n, input logic [1:0] c);
    press(2'h3);
    repeat (n) press(2'h1);
    press(2'h3);
    press(c);
    press(2'h3);
  endtask : edit
  task automatic flow(input logic [7:0] v, input int n);
    @(posedge core_clk);
    #1 flow_rate = v;
    repeat (n) @(posedge core_clk);
    #1;
  endtask : flow
  task automatic t_reset;
    chk(max_limit, MAX_LIM_RST);
    chk(min_limit, MIN_LIM_RST);
    chk(hold_off, HOLD_RST);
    chk({alarm_en, peak_en, log_en, menu_state}, 5'h10);
  endtask : t_reset
  task automatic t_band;
    flow(8'h32, 5);
    chk(relay_contact_a, 1);
    flow(8'h0A, 3);
    chk(relay_contact_b, 0);
    flow(8'h00, 3);
  endtask : t_band
  // hold-off of 1.0 s is 100 cycles here
  task automatic t_holdoff;
    flow(8'hFA, 3);
    chk(relay_contact_a, 1);
    flow(8'hFA, 50);
    chk(relay_contact_a, 1);
    flow(8'hFA, 60);
    chk(relay_contact_a, 0);
    flow(8'h00, 3);
  endtask : t_holdoff
  task automatic t_menu;
    press(2'h1);
    chk(menu_state, 0);
    press(2'h3);
    chk({menu_state, menu_item}, 6'h10);
    press(2'h1);
    chk(menu_item, 1);
    press(2'h2);
    press(2'h2);
    chk(menu_item, MI_LAST);
    press(2'h1);
    press(2'h3);
    chk({menu_state, menu_value}, 10'h2C8);
    press(2'h2);
    chk(menu_value, 8'hC7);
    press(2'h3);
    chk({menu_state, max_limit}, 10'h0C7);
  endtask : t_menu
  task automatic t_alarm;
    edit(3, 2'h2);
    chk(alarm_en, 0);
    flow(8'h32, 5);
    chk(relay_contact_a, 0);
    flow(8'h00, 3);
    edit(3, 2'h1);
  endtask : t_alarm
  task automatic t_peak;
    edit(4, 2'h1);
    chk(peak_en, 1);
    flow(8'hFA, 30);
    flow(8'h64, 20);
    flow(8'h00, 3);
    chk({peak_valid, peak_rate}, 9'h1FA);
    chk(peak_time_hund >= 16'd25 && peak_time_hund <= 16'd31, 1);
    flow(8'h14, 5);
    chk({peak_valid, peak_rate}, 9'h014);
    chk(peak_time_hund, 0);
    flow(8'h00, 3);
  endtask : t_peak
  // 1500 cycles at 255 is one tenth of volume and 75 s of flow
  task automatic t_log;
    chk({total_vol_tenths, total_seconds}, 0);
    edit(5, 2'h1);
    flow(8'hFF, 1500);
    flow(8'h00, 3);
    chk(total_minutes, 1);
    chk(total_vol_tenths, 1);
    edit(6, 2'h1);
    chk(total_hours, 0);
    chk({total_minutes, total_seconds}, 0);
    chk(total_vol_tenths, 1);
    edit(7, 2'h1);
    chk(total_vol_tenths, 0);
  endtask : t_log
  // hold-off stepped down past its floor must clamp at the minimum
  task automatic t_clamp;
    press(2'h3);
    press(2'h1);
    press(2'h1);
    press(2'h3);
    repeat (6) press(2'h2);
    press(2'h3);
    chk(hold_off, HOLD_MIN);
  endtask : t_clamp
  task automatic t_charge;
    #1 charging_pin = 1;
    repeat (10) @(posedge core_clk);
    chk(charge_indicator, 1);
    #1 charge_current_low_pin = 1;
    repeat (6) @(posedge core_clk);
    chk(charge_indicator, 0);
    #1 charge_current_low_pin = 0;
    repeat (6) @(posedge core_clk);
    chk(charge_indicator, 1);
    repeat (74) @(posedge core_clk);
    chk(charge_indicator, 0);
  endtask : t_charge
  initial begin
    repeat (16) @(posedge core_clk);
    #1 rst = 0;
    t_reset();
    t_band();
    t_holdoff();
    t_menu();
    t_alarm();
    t_peak();
    t_log();
    t_clamp();
    t_charge();
    conclude();
  end
endmodule : gas_flow_limit_monitor_bench
`default_nettype wire
